// File: flash_card_host_strobe_port.sv
// host controller driving the flash card strobes and lanes and decoding its status pins
`timescale 1ns/1ns
`include "flash_port_regs.svh"
module flash_card_host_strobe_port
	import flash_port_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = `FIFO_DEPTH
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// mode select
	input  op_mode_t         mode_sel,
	// command port
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic        cmd_write,
	input  space_t           cmd_space,
	input  wire logic [10:0] cmd_addr,
	input  wire logic [15:0] cmd_wdata,
	output logic             cmd_error,
	// read data stream
	output logic             rd_valid,
	input  wire logic        rd_ready,
	output logic [15:0]      rd_data,
	// decoded card status
	output logic             card_inserted,
	output logic             battery_status_two,
	output logic             audio_out_n,
	output logic             drive_active_presence_n,
	// card pins
	output logic [10:0]      card_addr,
	output logic             card_enable_one_n,
	output logic             card_enable_two_n,
	output logic             attr_select_n,
	output logic             out_enable_n,
	output logic             write_enable_n,
	output logic             io_read_strobe_n,
	output logic             io_write_strobe_n,
	output logic [15:0]      host_data_lines_o,
	output logic [15:0]      host_data_lines_oe,
	input  wire logic [15:0] host_data_lines_i,
	input  wire logic        status_pin_i,
	input  wire logic        card_detect_one_n,
	input  wire logic        card_detect_two_n
);
	typedef enum logic [1:0] {
		st_idle,
		st_setup,
		st_active,
		st_recover
	} state_t;

	localparam logic [7:0] SETUP_CNT   = 8'(`SETUP_CYC - 1);
	localparam logic [7:0] ACTIVE_CNT  = 8'(`ACTIVE_CYC - 1);
	localparam logic [7:0] RECOVER_CNT = 8'(`RECOVER_CYC - 1);

	// which strobe serves an access, none when the mode forbids it
	function automatic strobe_t strobe_kind(op_mode_t m, space_t s, logic wr);
		strobe_t k;
		k = strobe_none;
		case (m)
			mode_mem: begin
				if (s == space_mem || s == space_attr)
					k = wr ? strobe_we : strobe_oe; // R11 R16
			end
			mode_io: begin
				if (s == space_io)
					k = wr ? strobe_io_write_strobe_n : strobe_io_read_strobe_n; // R8 R9
				else if (s == space_attr)
					k = wr ? strobe_we : strobe_oe; // R12
			end
			mode_ide: begin
				if (s == space_task || s == space_data)
					k = wr ? strobe_io_write_strobe_n : strobe_io_read_strobe_n; // R10
			end
			default: k = strobe_none;
		endcase
		return k;
	endfunction : strobe_kind

	// data lanes carried by an access
	function automatic logic [15:0] lane_mask(space_t s);
		return (s == space_task || s == space_attr) ? `LANES_BYTE : `LANES_WORD; // R5 R6
	endfunction : lane_mask

	state_t      state_ff;
	op_mode_t    mode_ff;
	strobe_t     kind_ff;
	logic [7:0]  cnt_ff;
	logic        write_ff;
	logic [15:0] mask_ff;
	logic        cmd_ready_ff;
	logic        cmd_error_ff;
	logic        push_ff;
	logic [15:0] push_data_ff;
	logic [10:0] addr_ff;
	logic        ce1_n_ff;
	logic        ce2_n_ff;
	logic        reg_n_ff;
	logic        oe_n_ff;
	logic        we_n_ff;
	logic        io_read_strobe_n_n_ff;
	logic        io_write_strobe_n_n_ff;
	logic [15:0] dout_ff;
	logic [15:0] doe_ff;
	logic        inserted_ff;
	logic        bvd_ff;
	logic        audio_out_n_ff;
	logic        drive_active_presence_n_ff;
	logic        fifo_in_ready;
	logic        accept;
	strobe_t     req_kind;

	assign req_kind = strobe_kind(mode_ff, cmd_space, cmd_write);
	assign accept   = cmd_valid && cmd_ready_ff;

	// sequencing: setup, strobe low, recovery
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_ff <= st_idle;
			cnt_ff   <= '0;
			kind_ff  <= strobe_none;
			write_ff <= 1'b0;
			mask_ff  <= '0;
		end else begin
			case (state_ff)
				st_idle: begin
					if (accept && req_kind != strobe_none) begin
						state_ff <= st_setup;
						cnt_ff   <= SETUP_CNT;
						kind_ff  <= req_kind;
						write_ff <= cmd_write;
						mask_ff  <= lane_mask(cmd_space);
					end
				end
				st_setup: begin
					cnt_ff <= cnt_ff - 1'b1;
					if (cnt_ff == '0) begin
						state_ff <= st_active;
						cnt_ff   <= ACTIVE_CNT;
					end
				end
				st_active: begin
					cnt_ff <= cnt_ff - 1'b1;
					if (cnt_ff == '0) begin
						state_ff <= st_recover;
						cnt_ff   <= RECOVER_CNT;
					end
				end
				st_recover: begin
					cnt_ff <= cnt_ff - 1'b1;
					if (cnt_ff == '0)
						state_ff <= st_idle;
				end
				default: state_ff <= st_idle;
			endcase
		end
	end

	// mode changes only between accesses
	always_ff @(posedge clk_sys) begin
		if (rst)
			mode_ff <= mode_mem;
		else if (state_ff == st_idle && !accept)
			mode_ff <= mode_sel;
	end

	// command handshake and refusal
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cmd_ready_ff <= 1'b0;
			cmd_error_ff <= 1'b0;
		end else begin
			cmd_error_ff <= accept && req_kind == strobe_none; // R7
			cmd_ready_ff <= state_ff == st_idle && !accept && fifo_in_ready;
		end
	end

	// address and selects
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			addr_ff  <= '0;
			ce1_n_ff <= 1'b1;
			ce2_n_ff <= 1'b1;
			reg_n_ff <= 1'b1;
		end else if (accept && req_kind != strobe_none) begin
			if (mode_ff == mode_ide)
				addr_ff <= {8'h00, cmd_addr[`TASK_ADDR_MSB:0]}; // R15
			else
				addr_ff <= cmd_addr; // R16
			reg_n_ff <= !(cmd_space == space_attr); // R16
			ce1_n_ff <= 1'b0;
			ce2_n_ff <= (mode_ff == mode_ide) || (lane_mask(cmd_space) == `LANES_BYTE);
		end else if (state_ff == st_recover && cnt_ff == '0) begin
			ce1_n_ff <= 1'b1;
			ce2_n_ff <= 1'b1;
			reg_n_ff <= 1'b1;
		end
	end

	// strobes
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			oe_n_ff   <= 1'b1;
			we_n_ff   <= 1'b1;
			io_read_strobe_n_n_ff <= 1'b1;
			io_write_strobe_n_n_ff <= 1'b1;
		end else begin
			if (mode_ff == mode_ide) begin
				oe_n_ff <= 1'b0; // R14
				we_n_ff <= 1'b1; // R13
			end else if (state_ff == st_setup && cnt_ff == '0) begin
				oe_n_ff <= !(kind_ff == strobe_oe);
				we_n_ff <= !(kind_ff == strobe_we); // R11 R12
			end else if ((state_ff == st_active && cnt_ff == '0) || state_ff == st_idle) begin
				oe_n_ff <= 1'b1;
				we_n_ff <= 1'b1;
			end
			if (state_ff == st_setup && cnt_ff == '0) begin
				io_read_strobe_n_n_ff <= !(kind_ff == strobe_io_read_strobe_n); // R9 R10
				io_write_strobe_n_n_ff <= !(kind_ff == strobe_io_write_strobe_n); // R8 R10
			end else if ((state_ff == st_active && cnt_ff == '0) || mode_ff == mode_mem) begin
				io_read_strobe_n_n_ff <= 1'b1; // R7
				io_write_strobe_n_n_ff <= 1'b1;
			end
		end
	end

	// write data held through the trailing edge, released after recovery
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dout_ff <= '0;
			doe_ff  <= '0;
		end else if (accept && req_kind != strobe_none) begin
			dout_ff <= cmd_wdata & lane_mask(cmd_space); // R5 R6
			doe_ff  <= cmd_write ? lane_mask(cmd_space) : 16'h0000; // R17
		end else if (state_ff == st_recover && cnt_ff == '0) begin
			doe_ff <= '0;
		end
	end

	// read data sampled in the last strobe cycle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			push_ff      <= 1'b0;
			push_data_ff <= '0;
		end else begin
			push_ff <= state_ff == st_active && cnt_ff == '0 && !write_ff;
			if (state_ff == st_active && cnt_ff == '0)
				push_data_ff <= host_data_lines_i & mask_ff; // R5 R9
		end
	end

	// shared status pin and card detect decode
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			inserted_ff <= 1'b0;
			bvd_ff      <= 1'b1;
			audio_out_n_ff     <= 1'b1;
			drive_active_presence_n_ff     <= 1'b1;
		end else begin
			inserted_ff <= mode_ff != mode_ide && !card_detect_one_n && !card_detect_two_n; // R4
			bvd_ff      <= (mode_ff == mode_mem) ? status_pin_i : 1'b1; // R1
			audio_out_n_ff     <= (mode_ff == mode_io) ? status_pin_i : 1'b1; // R2
			drive_active_presence_n_ff     <= (mode_ff == mode_ide) ? status_pin_i : 1'b1; // R3
		end
	end

	read_fifo #(
		.WIDTH (WIDTH),
		.DEPTH (DEPTH)
	) u_read_fifo (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.in_valid  (push_ff),
		.in_ready  (fifo_in_ready),
		.in_data   (push_data_ff),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  (rd_data)
	);

	assign cmd_ready               = cmd_ready_ff;
	assign cmd_error               = cmd_error_ff;
	assign card_inserted           = inserted_ff;
	assign battery_status_two      = bvd_ff;
	assign audio_out_n             = audio_out_n_ff;
	assign drive_active_presence_n = drive_active_presence_n_ff;
	assign card_addr               = addr_ff;
	assign card_enable_one_n       = ce1_n_ff;
	assign card_enable_two_n       = ce2_n_ff;
	assign attr_select_n           = reg_n_ff;
	assign out_enable_n            = oe_n_ff;
	assign write_enable_n          = we_n_ff;
	assign io_read_strobe_n        = io_read_strobe_n_n_ff;
	assign io_write_strobe_n       = io_write_strobe_n_n_ff;
	assign host_data_lines_o       = dout_ff;
	assign host_data_lines_oe      = doe_ff;

	sequence io_wr_trailing;
		$rose(io_write_strobe_n_n_ff);
	endsequence

	sequence card_fully_in;
		mode_ff != mode_ide && !card_detect_one_n && !card_detect_two_n;
	endsequence

	ide_oe_low_a: assert property (@(posedge clk_sys) disable iff (rst) // R14
		$past(mode_ff) == mode_ide && mode_ff == mode_ide |-> !oe_n_ff)
		else $error("output enable not low in disk mode");
	ide_we_high_a: assert property (@(posedge clk_sys) disable iff (rst) // R13
		mode_ff == mode_ide |=> we_n_ff)
		else $error("write strobe active in disk mode");
	mem_io_quiet_a: assert property (@(posedge clk_sys) disable iff (rst) // R7
		mode_ff == mode_mem |=> io_read_strobe_n_n_ff && io_write_strobe_n_n_ff)
		else $error("io strobe in memory mode");
	io_wr_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // R8
		io_wr_trailing |-> doe_ff != 16'h0000 && state_ff == st_recover)
		else $error("write data gone at io write trailing edge");
	read_no_drive_a: assert property (@(posedge clk_sys) disable iff (rst) // R17
		(!io_read_strobe_n_n_ff || !oe_n_ff) && state_ff != st_idle && !write_ff |-> doe_ff == 16'h0000)
		else $error("host drives data during read");
	task_byte_a: assert property (@(posedge clk_sys) disable iff (rst) // R5
		accept && cmd_write && cmd_space == space_task && mode_ff == mode_ide |=> doe_ff == `LANES_BYTE)
		else $error("task access not byte wide");
	data_word_a: assert property (@(posedge clk_sys) disable iff (rst) // R6
		accept && cmd_write && cmd_space == space_data && mode_ff == mode_ide |=> doe_ff == `LANES_WORD)
		else $error("data transfer not word wide");
	ide_addr_high_a: assert property (@(posedge clk_sys) disable iff (rst) // R15
		mode_ff == mode_ide && state_ff != st_idle |-> addr_ff[10:3] == 8'h00)
		else $error("upper address lines not low in disk mode");
	io_we_attr_a: assert property (@(posedge clk_sys) disable iff (rst) // R12
		mode_ff == mode_io && !we_n_ff |-> !reg_n_ff)
		else $error("write strobe outside configuration space in io mode");
	detect_seen_a: assert property (@(posedge clk_sys) disable iff (rst) // R4
		card_fully_in ##1 mode_ff != mode_ide |-> inserted_ff)
		else $error("insertion not reported");
	refuse_flag_a: assert property (@(posedge clk_sys) disable iff (rst) // R7
		accept && mode_ff == mode_mem && cmd_space == space_io |=> cmd_error_ff && state_ff == st_idle)
		else $error("io access in memory mode not refused");

endmodule : flash_card_host_strobe_port

// File: flash_port_regs.svh
// timing and lane constants for the flash card host strobe port
// Behaviour
// R1: In memory-card mode the card holds its second battery-status line high at all times.
// R2: In I/O-card mode the card holds its audio line high at all times.
// R3: In disk-interface mode the shared status line is the drive-active and secondary-present indication.
// R4: In both card modes both card-detect lines low mean full insertion; in disk-interface mode they mean nothing.
// R5: In disk-interface mode each task-register access moves one byte on the low eight data lines.
// R6: In disk-interface mode each data transfer uses all sixteen data lines.
// R7: In memory-card mode the I/O read and write strobes are ignored, so none is issued.
// R8: In I/O-card mode write data is latched on the rising, trailing edge of the I/O write strobe.
// R9: In I/O-card mode the card drives read data while the I/O read strobe is held low.
// R10: In disk-interface mode the I/O strobes behave as in I/O-card mode.
// R11: In memory-card mode the write strobe writes both memory space and configuration registers.
// R12: In I/O-card mode the write strobe is used only for configuration register writes.
// R13: In disk-interface mode the write strobe is tied inactive high and ignored.
// R14: Disk-interface mode is selected by holding output enable low; in card modes it strobes reads.
// R15: In disk-interface mode address bits two to zero pick one of eight task registers, higher bits low.
// R16: In card modes the address with the attribute select picks I/O, memory, information or configuration.
// R17: The card drives the data lines only while a read strobe valid for the mode is low.
`ifndef FLASH_PORT_REGS_SVH
`define FLASH_PORT_REGS_SVH

`define CLK_PERIOD_NS  4
`define SETUP_NS       30
`define ACTIVE_NS      165
`define RECOVER_NS     30
`define SETUP_CYC      ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACTIVE_CYC     ((`ACTIVE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_CYC    ((`RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define LANES_BYTE     16'h00FF
`define LANES_WORD     16'hFFFF
`define TASK_ADDR_MSB  2
`define FIFO_DEPTH     16

`endif

// File: flash_port_pkg.sv
// types shared by the flash card host strobe port
package flash_port_pkg;

	typedef enum logic [1:0] {
		mode_mem,
		mode_io,
		mode_ide
	} op_mode_t;

	typedef enum logic [2:0] {
		space_mem,
		space_attr,
		space_io,
		space_task,
		space_data
	} space_t;

	typedef enum logic [2:0] {
		strobe_none,
		strobe_oe,
		strobe_we,
		strobe_io_read_strobe_n,
		strobe_io_write_strobe_n
	} strobe_t;

endpackage : flash_port_pkg

// File: read_fifo.sv
// read data fifo with registered flags
`timescale 1ns/1ns
module read_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wr_ptr_ff;
	logic [AW-1:0]    rd_ptr_ff;
	logic [AW:0]      level_ff;
	logic [AW:0]      nxt_level;
	logic             in_ready_ff;
	logic             out_valid_ff;
	logic             push;
	logic             pop;

	assign push      = in_valid && in_ready_ff;
	assign pop       = out_ready && out_valid_ff;
	assign in_ready  = in_ready_ff;
	assign out_valid = out_valid_ff;
	assign out_data  = mem_ff[rd_ptr_ff];

	always_comb begin
		nxt_level = level_ff;
		if (push && !pop)
			nxt_level = level_ff + 1'b1;
		else if (pop && !push)
			nxt_level = level_ff - 1'b1;
	end

	always_ff @(posedge clk_sys) begin
		if (push)
			mem_ff[wr_ptr_ff] <= in_data;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_ptr_ff    <= '0;
			rd_ptr_ff    <= '0;
			level_ff     <= '0;
			in_ready_ff  <= 1'b0;
			out_valid_ff <= 1'b0;
		end else begin
			if (push)
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
			level_ff     <= nxt_level;
			in_ready_ff  <= nxt_level != (AW+1)'(DEPTH);
			out_valid_ff <= nxt_level != '0;
		end
	end

endmodule : read_fifo

// File: card_model.sv
// behavioural flash card answering the host strobe port
`timescale 1ns/1ns
module card_model
	import flash_port_pkg::*;
(
	// mode and status
	input  op_mode_t         mode,
	input  wire logic        drive_active_presence_n_n,
	output logic             pin62,
	output logic             cd1_n,
	output logic             cd2_n,
	// card pins
	input  wire logic [10:0] addr,
	input  wire logic        ce1_n,
	input  wire logic        ce2_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic        io_read_strobe_n_n,
	input  wire logic        io_write_strobe_n_n,
	input  wire logic [15:0] bus,
	output logic [15:0]      drv_data,
	output logic             drv_en
);
	logic [15:0] regs [8];
	logic [15:0] last;
	logic        rd_act;

	initial begin
		for (int i = 0; i < 8; i++) regs[i] = 16'h0000;
		last = 16'h0000;
	end

	assign pin62 = (mode == mode_ide) ? drive_active_presence_n_n : 1'b1;
	assign cd1_n = 1'b0;
	assign cd2_n = 1'b0;
	// io strobes unused in memory mode, output enable not a read strobe in disk mode
	assign rd_act = !ce1_n && ((mode != mode_ide && !oe_n) || (mode != mode_mem && !io_read_strobe_n_n));
	assign drv_en = rd_act;
	// released lines show the inverse of the last driven word
	assign drv_data = rd_act ? regs[addr[2:0]] : ~last;

	always @(drv_data) if (rd_act) last = drv_data;

	// byte access with second enable high moves low lanes only; disk mode keeps it high and takes the word
	always @(posedge io_write_strobe_n_n) if (mode != mode_mem && !ce1_n) begin
		if (ce2_n && mode != mode_ide) regs[addr[2:0]][7:0] <= bus[7:0];
		else regs[addr[2:0]] <= bus;
	end

	always @(posedge we_n) if (mode != mode_ide && !ce1_n) begin
		if (ce2_n) regs[addr[2:0]][7:0] <= bus[7:0];
		else regs[addr[2:0]] <= bus;
	end
endmodule : card_model

// File: testbench.sv
// self-checking bench for the flash card host strobe port
`timescale 1ns/1ns
module testbench;
	import flash_port_pkg::*;
	logic clk_sys = 0, rst = 1, cmd_valid = 0, cmd_write = 0, rd_ready = 0, drive_active_presence_n_n = 1;
	op_mode_t mode_sel = mode_mem;
	space_t cmd_space = space_mem;
	logic [10:0] cmd_addr = 0, card_addr;
	logic [15:0] cmd_wdata = 0, rd_data, host_data_lines_o, host_data_lines_oe, host_data_lines_i, cdat;
	logic cmd_ready, cmd_error, rd_valid, card_inserted, battery_status_two, audio_out_n, drive_active_presence_n;
	logic card_enable_one_n, card_enable_two_n, attr_select_n, out_enable_n, write_enable_n;
	logic io_read_strobe_n, io_write_strobe_n, status_pin_i, card_detect_one_n, card_detect_two_n, cdrv;
	logic saw_we, saw_oe, saw_io_write_strobe_n, saw_io_read_strobe_n, hi_addr, wide, reg_sel;
	logic [15:0] oe_at;
	int mismatches = 0, num_checks = 0;

	always #2 clk_sys = ~clk_sys;
	assign host_data_lines_i = (host_data_lines_oe & host_data_lines_o) | (~host_data_lines_oe & cdat);

	flash_card_host_strobe_port dut (.clk_sys, .rst, .mode_sel, .cmd_valid, .cmd_ready, .cmd_write, .cmd_space,
		.cmd_addr, .cmd_wdata, .cmd_error, .rd_valid, .rd_ready, .rd_data, .card_inserted, .battery_status_two,
		.audio_out_n, .drive_active_presence_n, .card_addr, .card_enable_one_n, .card_enable_two_n, .attr_select_n,
		.out_enable_n, .write_enable_n, .io_read_strobe_n, .io_write_strobe_n, .host_data_lines_o,
		.host_data_lines_oe, .host_data_lines_i, .status_pin_i, .card_detect_one_n, .card_detect_two_n);

	card_model card (.mode(mode_sel), .drive_active_presence_n_n(drive_active_presence_n_n), .pin62(status_pin_i), .cd1_n(card_detect_one_n),
		.cd2_n(card_detect_two_n), .addr(card_addr), .ce1_n(card_enable_one_n), .ce2_n(card_enable_two_n),
		.oe_n(out_enable_n), .we_n(write_enable_n), .io_read_strobe_n_n(io_read_strobe_n), .io_write_strobe_n_n(io_write_strobe_n),
		.bus(host_data_lines_i), .drv_data(cdat), .drv_en(cdrv));

	// strobe activity seen during one command
	always @(negedge clk_sys) begin
		if (!write_enable_n) begin saw_we = 1; oe_at = host_data_lines_oe; end
		if (!io_write_strobe_n) begin saw_io_write_strobe_n = 1; oe_at = host_data_lines_oe; end
		if (!io_read_strobe_n) saw_io_read_strobe_n = 1;
		if (!out_enable_n && mode_sel != mode_ide) saw_oe = 1;
		if (!card_enable_one_n && card_addr[10:3] != 8'h00) hi_addr = 1;
		if (!card_enable_one_n && !card_enable_two_n) wide = 1;
		if (!card_enable_one_n && !attr_select_n) reg_sel = 1;
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	task automatic check_bit(input logic got, input logic exp, input string what);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask : check_bit

	task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check_word

	task automatic set_mode(input op_mode_t m);
		@(negedge clk_sys);
		mode_sel = m;
		repeat (6) @(negedge clk_sys);
	endtask : set_mode

	// one command: hold until taken, then wait for idle or error
	task automatic run_cmd(input logic wr, input space_t sp, input logic [10:0] a, input logic [15:0] wd,
		output logic err);
		int n;
		@(negedge clk_sys);
		{saw_we, saw_oe, saw_io_write_strobe_n, saw_io_read_strobe_n, hi_addr, wide, reg_sel, err} = 8'h00;
		oe_at = 16'h0000;
		cmd_valid = 1;
		cmd_write = wr;
		cmd_space = sp;
		cmd_addr  = a;
		cmd_wdata = wd;
		// ready seen at a falling edge means the next rising edge takes the command
		for (n = 0; n < 400 && cmd_ready !== 1'b1; n++) @(negedge clk_sys);
		if (n >= 400) begin mismatches++; $display("MISMATCH t=%0t command not taken", $time); end_sim(); end
		@(negedge clk_sys);
		cmd_valid = 0;
		// done once the enables are released, after two falling edges for a refused command
		for (n = 0; n < 120 && !(n > 1 && card_enable_one_n === 1'b1); n++) begin
			if (cmd_error === 1'b1) err = 1;
			@(negedge clk_sys);
		end
		if (n >= 120) begin mismatches++; $display("MISMATCH t=%0t command never finished", $time); end_sim(); end
	endtask : run_cmd

	task automatic get_read(output logic [15:0] d);
		int n;
		for (n = 0; n < 200 && rd_valid !== 1'b1; n++) @(negedge clk_sys);
		if (n >= 200) begin mismatches++; $display("MISMATCH t=%0t no read data", $time); end_sim(); end
		d = rd_data;
		rd_ready = 1;
		@(negedge clk_sys);
		rd_ready = 0;
		@(negedge clk_sys);
	endtask : get_read

	task automatic s_reset;
		check_bit(cmd_error, 1'b0, "error after reset");
		check_bit(io_write_strobe_n & io_read_strobe_n & write_enable_n, 1'b1, "strobes idle");
		check_word(host_data_lines_oe, 16'h0000, "lanes released");
		check_bit(rd_valid, 1'b0, "no read data");
	endtask : s_reset

	task automatic s_mem;
		logic e;
		logic [15:0] d;
		set_mode(mode_mem);
		check_bit(battery_status_two, 1'b1, "battery status");
		check_bit(card_inserted, 1'b1, "inserted");
		run_cmd(1, space_mem, 11'h003, 16'h1234, e);
		check_bit(saw_we & ~saw_io_write_strobe_n & ~saw_io_read_strobe_n, 1'b1, "mem write strobes");
		check_word(oe_at, 16'hFFFF, "mem write lanes");
		check_bit(wide & ~reg_sel, 1'b1, "mem word selects");
		run_cmd(0, space_mem, 11'h003, 16'h0000, e);
		check_bit(saw_oe & ~saw_io_read_strobe_n, 1'b1, "mem read strobes");
		get_read(d);
		check_word(d, 16'h1234, "mem read data");
		run_cmd(1, space_attr, 11'h005, 16'h003C, e);
		check_bit(saw_we, 1'b1, "config write strobe");
		check_word(oe_at, 16'h00FF, "config write lanes");
		check_bit(~wide & reg_sel, 1'b1, "config byte selects");
		run_cmd(0, space_attr, 11'h005, 16'h0000, e);
		get_read(d);
		check_word(d & 16'h00FF, 16'h003C, "config read data");
	endtask : s_mem

	task automatic s_refuse;
		op_mode_t rm [9] = '{mode_mem, mode_mem, mode_mem, mode_io, mode_io, mode_io, mode_ide, mode_ide, mode_ide};
		space_t rs [9] = '{space_io, space_task, space_data, space_mem, space_task, space_data,
			space_mem, space_attr, space_io};
		logic e;
		for (int i = 0; i < 9; i++) begin
			set_mode(rm[i]);
			run_cmd(i[0], rs[i], 11'h001, 16'h5555, e);
			check_bit(e, 1'b1, "refused command flagged");
			check_bit(saw_we | saw_io_write_strobe_n | saw_io_read_strobe_n | saw_oe, 1'b0, "refused command silent");
		end
	endtask : s_refuse

	task automatic s_io;
		logic e;
		logic [15:0] d;
		set_mode(mode_io);
		check_bit(audio_out_n, 1'b1, "audio line");
		run_cmd(1, space_io, 11'h002, 16'hBEEF, e);
		check_bit(saw_io_write_strobe_n & ~saw_we, 1'b1, "io write strobe");
		run_cmd(0, space_io, 11'h002, 16'h0000, e);
		check_bit(saw_io_read_strobe_n, 1'b1, "io read strobe");
		get_read(d);
		check_word(d, 16'hBEEF, "io read data");
		run_cmd(1, space_attr, 11'h004, 16'h0077, e);
		check_bit(saw_we & ~saw_io_write_strobe_n, 1'b1, "io config write");
	endtask : s_io

	task automatic s_ide;
		logic e;
		logic [15:0] d;
		set_mode(mode_ide);
		check_bit(out_enable_n, 1'b0, "disk select");
		check_bit(card_inserted, 1'b0, "detects ignored");
		run_cmd(1, space_task, 11'h006, 16'h00A7, e);
		check_bit(saw_io_write_strobe_n & ~saw_we & ~hi_addr, 1'b1, "task write");
		check_word(oe_at, 16'h00FF, "task write lanes");
		check_bit(wide | reg_sel, 1'b0, "task selects");
		run_cmd(0, space_task, 11'h006, 16'h0000, e);
		get_read(d);
		check_word(d & 16'h00FF, 16'h00A7, "task read");
		run_cmd(1, space_data, 11'h000, 16'hC0DE, e);
		check_word(oe_at, 16'hFFFF, "data write lanes");
		run_cmd(0, space_data, 11'h000, 16'h0000, e);
		get_read(d);
		check_word(d, 16'hC0DE, "data read");
		drive_active_presence_n_n = 0;
		repeat (4) @(negedge clk_sys);
		check_bit(drive_active_presence_n, 1'b0, "drive active");
		drive_active_presence_n_n = 1;
		repeat (4) @(negedge clk_sys);
		check_bit(drive_active_presence_n, 1'b1, "drive idle");
	endtask : s_ide

	// fill the read fifo with the drain stalled, then empty it
	task automatic s_fifo;
		logic e;
		logic [15:0] d;
		set_mode(mode_io);
		for (int i = 0; i < 16; i++) run_cmd(0, space_io, 11'h002, 16'h0000, e);
		repeat (10) @(negedge clk_sys);
		check_bit(cmd_ready, 1'b0, "full fifo refuses");
		for (int i = 0; i < 16; i++) begin
			get_read(d);
			check_word(d, 16'hBEEF, "drained word");
		end
		@(negedge clk_sys);
		check_bit(rd_valid, 1'b0, "fifo empty");
	endtask : s_fifo

	initial begin
		repeat (10) @(negedge clk_sys);
		rst = 0;
		repeat (4) @(negedge clk_sys);
		s_reset();
		s_mem();
		s_io();
		s_fifo();
		s_ide();
		s_refuse();
		end_sim();
	end
endmodule : testbench
